// *** prs_top.sv ***
// register file and pad steering for the peripheral pin route select block
// ----------------------------------------------------------------------
// Notes on behaviour
// - logic table 1 alt pin when bit5
// - logic table 0 alt pin when bit4
// - first register bits 0..2 enable event pins
// - sync serial alt pins when bit2
// - async serial alt pins when bit0
// - waves 3..5 alt only in split mode
// - waves 0..2 alt, low-byte channels when split
// - timer B output alt pin when bit0
// - each signal enabled or position-switched
// ----------------------------------------------------------------------
`include "prs_defs.svh"

module prs_top
   import prs_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // axi4-lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer A mode
   input wire logic timer_a_split_i,
   // peripheral outputs, enables and returns
   input wire logic [1:0] logic_table_out_i,
   input wire logic [2:0] event_out_i,
   input wire logic [3:0] sync_serial_out_i,
   input wire logic [3:0] sync_serial_oe_i,
   output logic [3:0] sync_serial_in_o,
   input wire logic [1:0] async_serial_out_i,
   input wire logic [1:0] async_serial_oe_i,
   output logic [1:0] async_serial_in_o,
   input wire logic [5:0] timer_a_wave_i,
   input wire logic [5:0] timer_a_wave_oe_i,
   input wire logic timer_b_out_i,
   input wire logic timer_b_oe_i,
   // pads: 16 route pairs, index order below
   input wire logic [15:0] pad_def_i,
   input wire logic [15:0] pad_alt_i,
   output logic [15:0] pad_def_o,
   output logic [15:0] pad_def_oe_n_o,
   output logic [15:0] pad_alt_o,
   output logic [15:0] pad_alt_oe_n_o,
   // event pads
   output logic [2:0] event_pad_o,
   output logic [2:0] event_pad_oe_n_o
);

   localparam int NPAIR = 16;

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   prs_reg_t logic_event_q;
   prs_reg_t serial_q;
   prs_reg_t timer_a_waves_q;
   prs_reg_t timer_b_q;

   // ----------------------------------------------------------------------
   // pad input synchronisers
   // ----------------------------------------------------------------------
   logic [15:0] pad_def_m_q;
   logic [15:0] pad_def_s_q;
   logic [15:0] pad_alt_m_q;
   logic [15:0] pad_alt_s_q;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pad_def_m_q <= 16'h0000;
         pad_def_s_q <= 16'h0000;
         pad_alt_m_q <= 16'h0000;
         pad_alt_s_q <= 16'h0000;
      end else begin
         pad_def_m_q <= pad_def_i;
         pad_def_s_q <= pad_def_m_q;
         pad_alt_m_q <= pad_alt_i;
         pad_alt_s_q <= pad_alt_m_q;
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------------
   logic aw_held_q;
   logic w_held_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic wr_hit;
   logic [1:0] wr_idx;

   // one write at a time: no new address or data until the response is taken
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
   assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign wr_hit = (awaddr_q[31:4] == 28'h000_0000) && (awaddr_q[1:0] == 2'b00);
   assign wr_idx = awaddr_q[3:2];

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PRS_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only byte lane 0 carries register data; upper lanes are ignored
   logic wr_lane0;
   assign wr_lane0 = wr_go & wr_hit & wstrb_q[0];

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         logic_event_q <= `PRS_RESET_VAL;
      end else if (wr_lane0 && wr_idx == `PRS_IDX_LOGIC_EVENT) begin
         logic_event_q <= wdata_q[7:0] & `PRS_MASK_LOGIC_EVENT;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         serial_q <= `PRS_RESET_VAL;
      end else if (wr_lane0 && wr_idx == `PRS_IDX_SERIAL) begin
         serial_q <= wdata_q[7:0] & `PRS_MASK_SERIAL;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_a_waves_q <= `PRS_RESET_VAL;
      end else if (wr_lane0 && wr_idx == `PRS_IDX_TIMER_A_WAVES) begin
         timer_a_waves_q <= wdata_q[7:0] & `PRS_MASK_TIMER_A_WAVES;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_b_q <= `PRS_RESET_VAL;
      end else if (wr_lane0 && wr_idx == `PRS_IDX_TIMER_B) begin
         timer_b_q <= wdata_q[7:0] & `PRS_MASK_TIMER_B;
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------------
   logic rd_hit;
   prs_reg_t rd_byte;

   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_hit = (s_axi_araddr[31:4] == 28'h000_0000) && (s_axi_araddr[1:0] == 2'b00);

   always_comb begin
      unique case (s_axi_araddr[3:2])
         `PRS_IDX_LOGIC_EVENT: rd_byte = logic_event_q;
         `PRS_IDX_SERIAL: rd_byte = serial_q;
         `PRS_IDX_TIMER_A_WAVES: rd_byte = timer_a_waves_q;
         `PRS_IDX_TIMER_B: rd_byte = timer_b_q;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PRS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         s_axi_rresp <= rd_hit ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // selection decode
   // ----------------------------------------------------------------------
   logic logic_table1_alt;
   logic logic_table0_alt;
   logic sync_serial_alt;
   logic async_serial_alt;
   logic timer_b_out_alt;
   logic [5:0] timer_a_wave_alt;

   assign logic_table1_alt = logic_event_q[`PRS_BIT_LOGIC_TABLE1];
   assign logic_table0_alt = logic_event_q[`PRS_BIT_LOGIC_TABLE0];
   assign sync_serial_alt = serial_q[`PRS_BIT_SYNC_SERIAL];
   assign async_serial_alt = serial_q[`PRS_BIT_ASYNC_SERIAL];
   assign timer_b_out_alt = timer_b_q[`PRS_BIT_TIMER_B];

   // in split mode waves 0..2 are the low-byte channels, 3..5 the high-byte
   genvar gw;
   generate
      for (gw = 0; gw < `PRS_NUM_WAVE; gw++) begin : g_wave
         if (gw < `PRS_NUM_SPLIT_BASE) begin : g_low
            assign timer_a_wave_alt[gw] = timer_a_waves_q[gw];
         end else begin : g_high
            // normal mode has no such output, so the bit is ignored there
            assign timer_a_wave_alt[gw] = timer_a_waves_q[gw] & timer_a_split_i;
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // pair table: 0-1 logic tables, 2-5 sync serial, 6-7 async serial,
   // 8-13 timer A waves, 14 timer B, 15 spare (never driven)
   // ----------------------------------------------------------------------
   logic [15:0] pair_sig;
   logic [15:0] pair_oe;
   logic [15:0] pair_alt;
   logic [15:0] pair_in;

   assign pair_sig = {1'b0, timer_b_out_i, timer_a_wave_i, async_serial_out_i,
                      sync_serial_out_i, logic_table_out_i};
   // timer A high waves only drive a pad in split mode
   assign pair_oe = {1'b0, timer_b_oe_i,
                     timer_a_wave_oe_i & {{3{timer_a_split_i}}, 3'b111},
                     async_serial_oe_i, sync_serial_oe_i, 2'b11};
   assign pair_alt = {1'b0, timer_b_out_alt, timer_a_wave_alt,
                      {2{async_serial_alt}}, {4{sync_serial_alt}},
                      logic_table1_alt, logic_table0_alt};

   genvar gp;
   generate
      for (gp = 0; gp < NPAIR; gp++) begin : g_pair
         prs_route_pair u_pair (
            .sig_i(pair_sig[gp]),
            .oe_i(pair_oe[gp]),
            .alt_i(pair_alt[gp]),
            .pad_def_i(pad_def_s_q[gp]),
            .pad_alt_i(pad_alt_s_q[gp]),
            .pad_def_o(pad_def_o[gp]),
            .pad_def_oe_n_o(pad_def_oe_n_o[gp]),
            .pad_alt_o(pad_alt_o[gp]),
            .pad_alt_oe_n_o(pad_alt_oe_n_o[gp]),
            .sig_o(pair_in[gp])
         );
      end
   endgenerate

   assign sync_serial_in_o = pair_in[5:2];
   assign async_serial_in_o = pair_in[7:6];

   // ----------------------------------------------------------------------
   // event pads: enable only, disabled pads stay released
   // ----------------------------------------------------------------------
   assign event_pad_o = event_out_i;
   assign event_pad_oe_n_o = ~logic_event_q[`PRS_NUM_EVENT-1:0];

endmodule // prs_top

// *** prs_defs.svh ***
// constants for the peripheral pin route select block
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// register indices (printed offsets), byte address is four times the index
`define PRS_IDX_LOGIC_EVENT 2'h0
`define PRS_IDX_SERIAL 2'h1
`define PRS_IDX_TIMER_A_WAVES 2'h2
`define PRS_IDX_TIMER_B 2'h3
`define PRS_ADDR_W 4
`define PRS_ADDR_TOP 4'h0

// implemented bit masks
`define PRS_MASK_LOGIC_EVENT 8'h37
`define PRS_MASK_SERIAL 8'h05
`define PRS_MASK_TIMER_A_WAVES 8'h3F
`define PRS_MASK_TIMER_B 8'h01
`define PRS_RESET_VAL 8'h00

// field positions
`define PRS_BIT_LOGIC_TABLE1 5
`define PRS_BIT_LOGIC_TABLE0 4
`define PRS_BIT_SYNC_SERIAL 2
`define PRS_BIT_ASYNC_SERIAL 0
`define PRS_BIT_TIMER_B 0
`define PRS_NUM_EVENT 3
`define PRS_NUM_WAVE 6
`define PRS_NUM_SPLIT_BASE 3

// response codes
`define PRS_RESP_OKAY 2'h0
`define PRS_RESP_SLVERR 2'h2

`endif

// *** prs_pkg.sv ***
// types for the peripheral pin route select block
package prs_pkg;
   typedef logic [7:0] prs_reg_t;
   typedef enum logic {PRS_POS_DEFAULT, PRS_POS_ALT} prs_pos_e;
endpackage

// *** prs_route_pair.sv ***
// one signal steered to a default or alternative pad
module prs_route_pair
   import prs_pkg::*;
(
   input wire logic sig_i,
   input wire logic oe_i,
   input wire logic alt_i,
   input wire logic pad_def_i,
   input wire logic pad_alt_i,
   output logic pad_def_o,
   output logic pad_def_oe_n_o,
   output logic pad_alt_o,
   output logic pad_alt_oe_n_o,
   output logic sig_o
);
   // selected pad drives when the peripheral drives; the other stays released
   assign pad_def_o = sig_i;
   assign pad_alt_o = sig_i;
   assign pad_def_oe_n_o = ~(oe_i & ~alt_i);
   assign pad_alt_oe_n_o = ~(oe_i & alt_i);
   // input path comes from the selected pad only
   assign sig_o = alt_i ? pad_alt_i : pad_def_i;
endmodule // prs_route_pair

// *** prs_top_sva.sv ***
// assertions on the ports of the pin route select block
module prs_top_sva
   import prs_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_a_split_i,
   input wire logic [1:0] logic_table_out_i,
   input wire logic [2:0] event_out_i,
   input wire logic [3:0] sync_serial_oe_i,
   input wire logic [15:0] pad_def_o,
   input wire logic [15:0] pad_def_oe_n_o,
   input wire logic [15:0] pad_alt_oe_n_o,
   input wire logic [2:0] event_pad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------------------------------------
   // pad steering
   // ----------------------------------------------------------------------
   pad_exclusive_a: assert property ((pad_def_oe_n_o | pad_alt_oe_n_o) == 16'hFFFF)
      else $error("both pads of one pair driven");
   spare_idle_a: assert property (pad_def_oe_n_o[15] && pad_alt_oe_n_o[15])
      else $error("spare pair driven");
   table_driven_a: assert property ((pad_def_oe_n_o[1:0] ^ pad_alt_oe_n_o[1:0]) == 2'h3)
      else $error("logic table pad not driven on exactly one side");
   table_value_a: assert property (pad_def_o[1:0] == logic_table_out_i)
      else $error("logic table level lost on its pad");
   event_pass_a: assert property (event_pad_o == event_out_i)
      else $error("event pad level differs from event output");
   sync_together_a: assert property ((sync_serial_oe_i == 4'hF) |->
      (pad_alt_oe_n_o[5:2] == {4{pad_alt_oe_n_o[2]}})) else $error("sync serial lines split");
   split_gate_a: assert property (!timer_a_split_i |-> (pad_alt_oe_n_o[13:11] == 3'h7))
      else $error("upper waves moved while timer not split");
   // ----------------------------------------------------------------------
   // register bus answers
   // ----------------------------------------------------------------------
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped before taken");
endmodule // prs_top_sva

bind prs_top prs_top_sva u_sva (.clk_i, .sys_rst_i, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .timer_a_split_i, .logic_table_out_i, .event_out_i, .sync_serial_oe_i,
   .pad_def_o, .pad_def_oe_n_o, .pad_alt_oe_n_o, .event_pad_o);

// *** prs_pad_model.sv ***
// pad side model: an outside driver on every pad that the block releases
module prs_pad_model (
   input wire logic [15:0] def_drv_i,
   input wire logic [15:0] def_oe_n_i,
   input wire logic [15:0] alt_drv_i,
   input wire logic [15:0] alt_oe_n_i,
   input wire logic [15:0] ext_def_i,
   input wire logic [15:0] ext_alt_i,
   output logic [15:0] def_lvl_o,
   output logic [15:0] alt_lvl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pad takes the outside level, never the stale block value
   assign def_lvl_o = (def_oe_n_i & ext_def_i) | (~def_oe_n_i & def_drv_i);
   assign alt_lvl_o = (alt_oe_n_i & ext_alt_i) | (~alt_oe_n_i & alt_drv_i);
endmodule // prs_pad_model

// *** peripheral_pin_route_select_tb.sv ***
// self-checking bench for the pin route select block
`include "prs_defs.svh"
module peripheral_pin_route_select_tb
   import prs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0;
   logic sys_rst_i = 1;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, timer_a_split_i = 1, timer_b_oe_i = 1;
   logic [1:0] s_axi_bresp, s_axi_rresp, async_serial_in_o, async_serial_oe_i = 2'h3;
   logic [3:0] sync_serial_in_o, sync_serial_oe_i = 4'hF;
   logic [5:0] timer_a_wave_oe_i = 6'h3F;
   logic [17:0] pat = 18'h0_0000;
   logic [15:0] ext_def = 16'h0000, ext_alt = 16'h0000;
   logic [15:0] pad_def_o, pad_def_oe_n_o, pad_alt_o, pad_alt_oe_n_o;
   logic [2:0] event_pad_o, event_pad_oe_n_o;
   wire logic [15:0] pad_def_i, pad_alt_i;
   wire logic [1:0] logic_table_out_i = pat[1:0];
   wire logic [2:0] event_out_i = pat[4:2];
   wire logic [3:0] sync_serial_out_i = pat[8:5];
   wire logic [1:0] async_serial_out_i = pat[10:9];
   wire logic [5:0] timer_a_wave_i = pat[16:11];
   wire logic timer_b_out_i = pat[17];
   int fails = 0, num_checks = 0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) pat <= pat + 18'h0_0001;
   prs_top uut (.clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .timer_a_split_i, .logic_table_out_i, .event_out_i, .sync_serial_out_i,
      .sync_serial_oe_i, .sync_serial_in_o, .async_serial_out_i, .async_serial_oe_i,
      .async_serial_in_o, .timer_a_wave_i, .timer_a_wave_oe_i, .timer_b_out_i, .timer_b_oe_i,
      .pad_def_i, .pad_alt_i, .pad_def_o, .pad_def_oe_n_o, .pad_alt_o, .pad_alt_oe_n_o,
      .event_pad_o, .event_pad_oe_n_o);
   prs_pad_model pads (.def_drv_i(pad_def_o), .def_oe_n_i(pad_def_oe_n_o), .alt_drv_i(pad_alt_o),
      .alt_oe_n_i(pad_alt_oe_n_o), .ext_def_i(ext_def), .ext_alt_i(ext_alt),
      .def_lvl_o(pad_def_i), .alt_lvl_o(pad_alt_i));
   // ----------------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
         input logic [3:0] s = 4'hF);
      logic aw_ok;
      logic w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_i);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1;
            s_axi_awvalid <= 0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   // rready comes late on purpose, so the slave must hold its answer
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1;
      @(posedge clk_i);
      s_axi_rready <= 0;
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic chk_pads(input logic [15:0] alt_n, input logic [15:0] def_n,
         input logic [2:0] ev_n);
      chk(32'(pad_alt_oe_n_o), 32'(alt_n));
      chk(32'(pad_def_oe_n_o), 32'(def_n));
      chk(32'(event_pad_oe_n_o), 32'(ev_n));
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      #20us;
      fails++;
      wrap_up;
   end
   initial begin
      logic [7:0] msk [4];
      msk = '{`PRS_MASK_LOGIC_EVENT, `PRS_MASK_SERIAL, `PRS_MASK_TIMER_A_WAVES, `PRS_MASK_TIMER_B};
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 0;
      for (int i = 0; i < 4; i++) axi_rd(32'(i * 4), 32'h0000_0000, `PRS_RESP_OKAY);
      chk_pads(16'hFFFF, 16'h8000, 3'h7);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         axi_wr(32'(i * 4), 32'hFFFF_FFFF, `PRS_RESP_OKAY);
         axi_rd(32'(i * 4), {24'h00_0000, msk[i]}, `PRS_RESP_OKAY);
      end
      chk_pads(16'h8000, 16'hFFFF, 3'h0);
      chk(32'(pad_alt_o), 32'({1'b0, pat[17:5], pat[1:0]}));
      timer_a_split_i <= 0;
      @(posedge clk_i);
      chk(32'(pad_alt_oe_n_o[13:8]), 32'h0000_0038);
      timer_a_split_i <= 1;
      $display("test alternative positions done");
      axi_wr(32'h0000_0000, 32'h0000_0000, `PRS_RESP_OKAY, 4'h0);
      axi_rd(32'h0000_0000, 32'h0000_0037, `PRS_RESP_OKAY);
      axi_wr(32'h0000_0010, 32'h0000_00FF, `PRS_RESP_SLVERR);
      axi_rd(32'h0000_0010, 32'h0000_0000, `PRS_RESP_SLVERR);
      axi_rd(32'h0000_0002, 32'h0000_0000, `PRS_RESP_SLVERR);
      $display("test refused accesses done");
      axi_wr(32'h0000_0000, 32'h0000_0000, `PRS_RESP_OKAY);
      chk_pads(16'h8003, 16'hFFFC, 3'h7);
      async_serial_oe_i <= 2'h0;
      sync_serial_oe_i <= 4'h0;
      ext_alt <= 16'h00A8;
      ext_def <= 16'h0054;
      repeat (4) @(posedge clk_i);
      chk(32'(async_serial_in_o), 32'h0000_0002);
      chk(32'(sync_serial_in_o), 32'h0000_000A);
      for (int i = 1; i < 4; i++) axi_wr(32'(i * 4), 32'h0000_0000, `PRS_RESP_OKAY);
      repeat (4) @(posedge clk_i);
      chk(32'(async_serial_in_o), 32'h0000_0001);
      chk(32'(sync_serial_in_o), 32'h0000_0005);
      async_serial_oe_i <= 2'h3;
      sync_serial_oe_i <= 4'hF;
      @(posedge clk_i);
      chk_pads(16'hFFFF, 16'h8000, 3'h7);
      $display("test return to defaults done");
      wrap_up;
   end
endmodule // peripheral_pin_route_select_tb
